// ---- occ_top.sv ----
/*
  Oscillator control, status and tuning registers with a reference clock
  output generator, behind an AXI4-Lite slave.
  Assumes oscillator status and configuration inputs are asynchronous and a
  pad outside applies the pin level, mix code, output enable and slew.
*/
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// Function
// - Software PLL enable with 8 MHz selection gives 32 MHz.
// - Codes 1111 to 1100 select 16, 8, 4, 2 MHz high-frequency.
// - Codes 1011 to 1000 select 1 MHz down to 125 kHz high-frequency.
// - Codes 0111 to 0100 select 500 kHz default down to 62.5 kHz medium.
// - Start-up done reads 1 only when running from configured source.
// - Timer1 ready bit shows whether Timer1 oscillator is usable.
// - Reference generator is clocked only from the system clock.
// - Reference generator runs only while its enable bit is set.
// - Pin carries reference only when pin drive and enable are set.
// - Three-bit divider field offers eight division ratios.
// - Two-bit duty field gives 0, 25, 50 or 75 percent.
// - Duty code 11 75%, 10 50%, 01 25%, 00 held low.
// - Undivided selection passes source clock, except 0% stays low.
// - Divide-by-two 25% and 75% use both source clock edges.
// - Slew-limit bit set applies limiting, clear removes it.
// - Reset disables the generator and restores its control defaults.
// - Crystal modes keep the reference output off the shared pin.
// - Quarter oscillator output has pin priority over the reference.
module occ_top #(
  parameter int unsigned ADDR_W = 32,
  parameter int unsigned CNT_W  = 7
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              timer1_osc_enable,
  input  wire logic              timer1_osc_running,
  input  wire logic              pll_locked,
  input  wire logic              osc_startup_timer_expired,
  input  wire logic              hf_internal_osc_ready,
  input  wire logic              hf_internal_osc_locked,
  input  wire logic              hf_internal_osc_stable,
  input  wire logic              mf_internal_osc_ready,
  input  wire logic              lf_internal_osc_ready,
  input  wire logic [2:0]        osc_mode_config,
  input  wire logic              config_pll_force,
  input  wire logic              fosc_quarter_output_enable,
  output occ_pkg::occ_int_src_e  int_src_q,
  output logic [24:0]            int_freq_hz_q,
  output logic                   pll_active_q,
  output occ_pkg::occ_sys_src_e  sysclk_src_q,
  output logic [5:0]             freq_trim_q,
  output logic                   refgen_output_pin_q,
  output logic                   refgen_output_pin_oe_q,
  output occ_pkg::occ_mix_e      refgen_clk_mix_q,
  output logic                   refgen_slew_limit_q
);

  localparam int unsigned SYNC_W = 14;

  logic [SYNC_W-1:0]        sync1_q;
  logic [SYNC_W-1:0]        sync2_q;
  occ_pkg::occ_ctrl_s       ctrl_q;
  occ_pkg::occ_refgen_cfg_s refcfg_q;
  logic [ADDR_W-1:0]        awaddr_q;
  logic [7:0]               wdata_q;
  logic                     wstrb_q;
  logic [1:0]               fq_cnt_q;
  logic                     t1_en_s, t1_run_s, pll_lock_s, tmr_done_s, hf_rdy_s, hf_lck_s;
  logic                     mf_rdy_s, lf_rdy_s, hf_stb_s, pll_force_s, fq_en_s;
  logic [2:0]               mode_s;
  logic                     commit, wr_ctrl, wr_tune, wr_ref, wr_hit, ar_hs, rd_hit;
  logic [ADDR_W-1:0]        araddr;
  logic [7:0]               status, rd_byte;
  logic                     pll_on, crystal, ref_level;
  logic [3:0]               fsel;
  logic [24:0]              freq_d;
  occ_pkg::occ_int_src_e    src_d;
  occ_pkg::occ_sys_src_e    sys_d;
  occ_pkg::occ_mix_e        ref_mix;
  logic                     pin_d, oe_d;
  occ_pkg::occ_mix_e        mix_d;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {timer1_osc_enable, timer1_osc_running, pll_locked, osc_startup_timer_expired,
                  hf_internal_osc_ready, hf_internal_osc_locked, mf_internal_osc_ready,
                  lf_internal_osc_ready, hf_internal_osc_stable, osc_mode_config,
                  config_pll_force, fosc_quarter_output_enable};
      sync2_q <= sync1_q;
    end
  end

  assign {t1_en_s, t1_run_s, pll_lock_s, tmr_done_s, hf_rdy_s, hf_lck_s, mf_rdy_s, lf_rdy_s,
          hf_stb_s, mode_s, pll_force_s, fq_en_s} = sync2_q;

  // Write path: address and data taken in either order, answer after both.
  assign commit  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_ctrl = awaddr_q == ADDR_W'(occ_pkg::OFS_OSC_CTRL);
  assign wr_tune = awaddr_q == ADDR_W'(occ_pkg::OFS_OSC_TUNE);
  assign wr_ref  = awaddr_q == ADDR_W'(occ_pkg::OFS_REFGEN_CTRL);
  assign wr_hit  = wr_ctrl || wr_tune || wr_ref || awaddr_q == ADDR_W'(occ_pkg::OFS_OSC_STAT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= occ_pkg::RESP_OKAY;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_q      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata[7:0];
        wstrb_q      <= s_axi_wstrb[0];
      end
      if (commit) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? occ_pkg::RESP_OKAY : occ_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Reset restores every control field, generator disabled.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q      <= occ_pkg::OSC_CTRL_RST;
      freq_trim_q <= occ_pkg::OSC_TUNE_RST;
      refcfg_q    <= occ_pkg::REFGEN_CTRL_RST;
    end else if (commit && wstrb_q) begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_q & occ_pkg::OSC_CTRL_MASK;
      end
      if (wr_tune) begin
        freq_trim_q <= wdata_q[5:0];
      end
      if (wr_ref) begin
        refcfg_q <= wdata_q;
      end
    end
  end

  // Live status bits; Timer1 always ready when its oscillator is off.
  // Start-up done only while running from the configured source.
  assign status = {!t1_en_s || t1_run_s, pll_lock_s,
                   tmr_done_s && ctrl_q.sysclk_sel == occ_pkg::SYSSEL_CFG,
                   hf_rdy_s, hf_lck_s, mf_rdy_s, lf_rdy_s, hf_stb_s};

  // Read path: answer one cycle after the address is taken.
  assign ar_hs   = s_axi_arvalid && s_axi_arready;
  assign araddr  = s_axi_araddr;
  assign rd_byte = (araddr == ADDR_W'(occ_pkg::OFS_OSC_CTRL)) ? ctrl_q :
                   (araddr == ADDR_W'(occ_pkg::OFS_OSC_STAT)) ? status :
                   (araddr == ADDR_W'(occ_pkg::OFS_OSC_TUNE)) ? {2'h0, freq_trim_q} :
                   (araddr == ADDR_W'(occ_pkg::OFS_REFGEN_CTRL)) ? refcfg_q : 8'h00;
  assign rd_hit  = araddr == ADDR_W'(occ_pkg::OFS_OSC_CTRL) || araddr == ADDR_W'(occ_pkg::OFS_OSC_STAT) ||
                   araddr == ADDR_W'(occ_pkg::OFS_OSC_TUNE) || araddr == ADDR_W'(occ_pkg::OFS_REFGEN_CTRL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= occ_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= rd_hit ? occ_pkg::RESP_OKAY : occ_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Internal oscillator frequency selection.
  assign fsel   = ctrl_q.freq_sel;
  assign pll_on = pll_force_s || ctrl_q.pll_en;
  // PLL on 8 MHz; HF codes; MF codes.
  assign freq_d = (pll_on && fsel == occ_pkg::FSEL_8M) ? occ_pkg::F_PLL :
                  fsel[3] ? (occ_pkg::F_HF_MAX >> (~fsel[2:0])) :
                  fsel[2] ? (occ_pkg::F_MF_MAX >> (~fsel[1:0])) :
                  (fsel == occ_pkg::FSEL_HF_LOW) ? (occ_pkg::F_HF_MAX >> occ_pkg::HF_LOW_SHIFT) :
                  (fsel == occ_pkg::FSEL_MF_LOW) ? (occ_pkg::F_MF_MAX >> occ_pkg::MF_LOW_SHIFT) :
                  occ_pkg::F_LF;
  assign src_d  = (fsel[3] || fsel == occ_pkg::FSEL_HF_LOW) ? occ_pkg::SRC_HF :
                  (fsel[2] || fsel == occ_pkg::FSEL_MF_LOW) ? occ_pkg::SRC_MF : occ_pkg::SRC_LF;
  assign sys_d  = ctrl_q.sysclk_sel[1] ? occ_pkg::SYS_INT :
                  (ctrl_q.sysclk_sel == occ_pkg::SYSSEL_T1) ? occ_pkg::SYS_T1 : occ_pkg::SYS_CFG;

  // Generator runs on the system clock only.
  occ_refgen #(
    .CNT_W (CNT_W)
  ) u_refgen (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cfg     (refcfg_q),
    .level_q (ref_level),
    .mix_q   (ref_mix)
  );

  // Crystal modes own the pin; quarter output wins next.
  // Reference reaches the pin only with enable and pin drive.
  assign crystal = mode_s == occ_pkg::MODE_XTAL_LOW || mode_s == occ_pkg::MODE_XTAL_STD ||
                   mode_s == occ_pkg::MODE_XTAL_FAST;
  assign oe_d    = !crystal && (fq_en_s || (refcfg_q.enable && refcfg_q.pin_drive));
  assign pin_d   = crystal ? 1'b0 : fq_en_s ? fq_cnt_q[1] : (oe_d && ref_level);
  assign mix_d   = (crystal || fq_en_s || !oe_d) ? occ_pkg::MIX_LEVEL : ref_mix;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fq_cnt_q               <= '0;
      int_freq_hz_q          <= occ_pkg::F_MF_MAX;
      int_src_q              <= occ_pkg::SRC_MF;
      pll_active_q           <= 1'b0;
      sysclk_src_q           <= occ_pkg::SYS_CFG;
      refgen_output_pin_q    <= 1'b0;
      refgen_output_pin_oe_q <= 1'b0;
      refgen_clk_mix_q       <= occ_pkg::MIX_LEVEL;
      refgen_slew_limit_q    <= 1'b0;
    end else begin
      fq_cnt_q               <= fq_cnt_q + 1'b1;
      int_freq_hz_q          <= freq_d;
      int_src_q              <= src_d;
      pll_active_q           <= pll_on;
      sysclk_src_q           <= sys_d;
      refgen_output_pin_q    <= pin_d;
      refgen_output_pin_oe_q <= oe_d;
      refgen_clk_mix_q       <= mix_d;
      refgen_slew_limit_q    <= refcfg_q.slew_limit;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pll_freq_32m: assert property (ctrl_q.pll_en && fsel == occ_pkg::FSEL_8M
      |=> int_freq_hz_q == occ_pkg::F_PLL)
    else $error("PLL with 8 MHz selection did not give 32 MHz.");
  a_hf_top_code: assert property (fsel == 4'hF
      |=> int_freq_hz_q == occ_pkg::F_HF_MAX && int_src_q == occ_pkg::SRC_HF)
    else $error("Code 1111 did not give 16 MHz high-frequency.");
  a_mf_default: assert property ($rose(aresetn) |-> fsel == occ_pkg::FSEL_MF_500K
      ##1 int_freq_hz_q == occ_pkg::F_MF_MAX)
    else $error("Reset default frequency is not 500 kHz.");
  a_sysclk_timer1: assert property (ctrl_q.sysclk_sel == occ_pkg::SYSSEL_T1
      |=> sysclk_src_q == occ_pkg::SYS_T1)
    else $error("Timer1 clock select not decoded.");
  a_startup_internal: assert property (ar_hs && araddr == ADDR_W'(occ_pkg::OFS_OSC_STAT)
      && ctrl_q.sysclk_sel != occ_pkg::SYSSEL_CFG |=> !s_axi_rdata[occ_pkg::STAT_STARTUP_BIT])
    else $error("Start-up done read as set on internal source.");
  a_refgen_idle: assert property ((!refcfg_q.enable && !fq_en_s) [*3] |-> !refgen_output_pin_q)
    else $error("Pin active while generator disabled.");
  a_pin_needs_drive: assert property (refgen_output_pin_oe_q |-> $past(fq_en_s || (refcfg_q.enable
      && refcfg_q.pin_drive)))
    else $error("Pin driven without pin drive enable.");
  a_duty_zero_low: assert property ((refcfg_q.duty == occ_pkg::DUTY_0 && !fq_en_s) [*3]
      |-> !refgen_output_pin_q && refgen_clk_mix_q == occ_pkg::MIX_LEVEL)
    else $error("Zero duty did not hold the pin low.");
  a_reset_disables: assert property ($rose(aresetn) |-> !refcfg_q.enable && !refgen_output_pin_oe_q)
    else $error("Generator enabled after reset.");
  a_crystal_no_drive: assert property (crystal |=> !refgen_output_pin_oe_q)
    else $error("Pin driven in crystal mode.");
  a_quarter_priority: assert property (!crystal && fq_en_s |=> refgen_output_pin_oe_q
      && refgen_clk_mix_q == occ_pkg::MIX_LEVEL)
    else $error("Quarter output lost pin priority.");

  c_status_read: cover property (ar_hs && araddr == ADDR_W'(occ_pkg::OFS_OSC_STAT));
  c_write_done: cover property (s_axi_bvalid && s_axi_bready && wr_ref);
  c_ref_on_pin: cover property (refgen_output_pin_oe_q && !fq_en_s && refgen_output_pin_q);
  c_quarter_out: cover property (refgen_output_pin_oe_q && fq_en_s);

endmodule : occ_top

// ---- occ_pkg.sv ----
/*
  Constants, field layouts and carrier types for the oscillator control and
  reference clock output block.
  Assumes a 32-bit AXI4-Lite register bus and one system clock.
*/
package occ_pkg;

  // Register byte offsets, one aligned 32-bit word each.
  localparam logic [3:0] OFS_OSC_CTRL    = 4'h0;
  localparam logic [3:0] OFS_OSC_STAT    = 4'h4;
  localparam logic [3:0] OFS_OSC_TUNE    = 4'h8;
  localparam logic [3:0] OFS_REFGEN_CTRL = 4'hC;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset values and writable-bit masks.
  localparam logic [7:0] OSC_CTRL_RST    = 8'h38;
  localparam logic [7:0] OSC_CTRL_MASK   = 8'hFB;
  localparam logic [5:0] OSC_TUNE_RST    = 6'h00;
  localparam logic [7:0] REFGEN_CTRL_RST = 8'h10;

  // Internal frequency select codes.
  localparam logic [3:0] FSEL_8M      = 4'hE;
  localparam logic [3:0] FSEL_HF_LOW  = 4'h3;
  localparam logic [3:0] FSEL_MF_LOW  = 4'h2;
  localparam logic [3:0] FSEL_MF_500K = 4'h7;

  // Frequencies in Hz and shift counts for the two low codes.
  localparam logic [24:0] F_PLL    = 25'h1E84800;
  localparam logic [24:0] F_HF_MAX = 25'h0F42400;
  localparam logic [24:0] F_MF_MAX = 25'h007A120;
  localparam logic [24:0] F_LF     = 25'h0007918;
  localparam logic [3:0]  HF_LOW_SHIFT = 4'h9;
  localparam logic [3:0]  MF_LOW_SHIFT = 4'h4;

  localparam logic [1:0] SYSSEL_CFG = 2'h0;
  localparam logic [1:0] SYSSEL_T1  = 2'h1;

  // Oscillator mode codes that use the shared pin for a crystal.
  localparam logic [2:0] MODE_XTAL_LOW  = 3'h0;
  localparam logic [2:0] MODE_XTAL_STD  = 3'h1;
  localparam logic [2:0] MODE_XTAL_FAST = 3'h2;

  localparam logic [1:0] DUTY_0  = 2'h0;
  localparam logic [1:0] DUTY_25 = 2'h1;
  localparam logic [1:0] DUTY_50 = 2'h2;
  localparam logic [1:0] DUTY_75 = 2'h3;
  localparam logic [2:0] DIV_BASE = 3'h0;
  localparam logic [2:0] DIV_2    = 3'h1;

  // Status bit positions.
  localparam int unsigned STAT_STARTUP_BIT = 5;

  typedef struct packed {
    logic       pll_en;
    logic [3:0] freq_sel;
    logic       rsvd;
    logic [1:0] sysclk_sel;
  } occ_ctrl_s;

  typedef struct packed {
    logic       enable;
    logic       pin_drive;
    logic       slew_limit;
    logic [1:0] duty;
    logic [2:0] div;
  } occ_refgen_cfg_s;

  typedef enum logic [2:0] {
    SRC_LF = 3'b001,
    SRC_MF = 3'b010,
    SRC_HF = 3'b100
  } occ_int_src_e;

  typedef enum logic [2:0] {
    SYS_CFG = 3'b001,
    SYS_T1  = 3'b010,
    SYS_INT = 3'b100
  } occ_sys_src_e;

  // How the pad combines the pin level with the system clock.
  typedef enum logic [1:0] {
    MIX_LEVEL = 2'h0,
    MIX_AND   = 2'h1,
    MIX_OR    = 2'h2,
    MIX_CLK   = 2'h3
  } occ_mix_e;

endpackage : occ_pkg

// ---- occ_refgen.sv ----
/*
  Reference clock divider and duty cycle generator.
  Assumes it runs on the system clock and that the pad applies the mix code.
*/
`timescale 1ns/1ns
module occ_refgen #(
  parameter int unsigned CNT_W = 7
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire occ_pkg::occ_refgen_cfg_s cfg,
  output logic                          level_q,
  output occ_pkg::occ_mix_e             mix_q
);

  localparam logic [2:0]       SHIFT_TOP = 3'(CNT_W);
  localparam logic [CNT_W-1:0] CNT_ONES  = {CNT_W{1'b1}};

  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  cnt_d;
  logic [CNT_W-1:0]  last;
  logic [CNT_W:0]    period;
  logic [CNT_W:0]    quarter;
  logic [CNT_W:0]    high_cnt;
  logic              level_d;
  occ_pkg::occ_mix_e mix_d;

  assign last     = CNT_ONES >> (SHIFT_TOP - cfg.div);
  assign period   = {1'b0, last} + 1'b1;
  assign quarter  = period >> 2;
  assign high_cnt = (cfg.duty == occ_pkg::DUTY_25) ? quarter :
                    (cfg.duty == occ_pkg::DUTY_50) ? (quarter << 1) :
                    (cfg.duty == occ_pkg::DUTY_75) ? (CNT_W+1)'(quarter * 3'h3) : '0;
  assign cnt_d    = (!cfg.enable || cnt_q >= last) ? '0 : cnt_q + 1'b1;

  // Base clock passed through; divide-by-two at 25% and 75% mixes both edges.
  assign level_d = !cfg.enable ? 1'b0 :
                   (cfg.duty == occ_pkg::DUTY_0) ? 1'b0 :
                   (cfg.div == occ_pkg::DIV_BASE) ? 1'b1 :
                   (cfg.div == occ_pkg::DIV_2) ? (cnt_q == '0) :
                   ({1'b0, cnt_q} < high_cnt);
  assign mix_d   = (!cfg.enable || cfg.duty == occ_pkg::DUTY_0) ? occ_pkg::MIX_LEVEL :
                   (cfg.div == occ_pkg::DIV_BASE) ? occ_pkg::MIX_CLK :
                   (cfg.div != occ_pkg::DIV_2) ? occ_pkg::MIX_LEVEL :
                   (cfg.duty == occ_pkg::DUTY_25) ? occ_pkg::MIX_AND :
                   (cfg.duty == occ_pkg::DUTY_75) ? occ_pkg::MIX_OR : occ_pkg::MIX_LEVEL;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q   <= '0;
      level_q <= 1'b0;
      mix_q   <= occ_pkg::MIX_LEVEL;
    end else begin
      cnt_q   <= cnt_d;
      level_q <= level_d;
      mix_q   <= mix_d;
    end
  end

endmodule : occ_refgen

// ---- occ_ext_dev.sv ----
/*
  Model of an external device clocked from the reference output pin.
  Assumes the pin line has a pull-down, so a released pin reads 0.
*/
`timescale 1ns/1ns
module occ_ext_dev (
  input  wire logic        aclk,
  input  wire logic        pin,
  input  wire logic        oe,
  input  wire logic        clr,
  output logic [15:0]      high_cnt_q,
  output logic [15:0]      rise_cnt_q
);
  logic prev_q;
  wire  pin_level = oe & pin;

  // Counts high samples and rising edges seen on the line.
  always_ff @(posedge aclk) begin
    prev_q     <= pin_level;
    high_cnt_q <= clr ? 16'h0000 : high_cnt_q + 16'(pin_level);
    rise_cnt_q <= clr ? 16'h0000 : rise_cnt_q + 16'(pin_level & ~prev_q);
  end
endmodule : occ_ext_dev

// ---- osc_control_and_ref_clock_out_bench.sv ----
/*
  Self-checking bench for the oscillator control and reference clock block.
  Assumes the AXI4-Lite slave of occ_top and the pin model occ_ext_dev.
*/
`timescale 1ns/1ns
module osc_control_and_ref_clock_out_bench;
  typedef struct packed {logic [3:0] code; logic [24:0] hz;} occ_row_s;
  localparam occ_row_s ROWS [12] = '{'{4'hF, 25'hF42400}, '{4'hE, 25'h7A1200}, '{4'hD, 25'h3D0900},
    '{4'hC, 25'h1E8480}, '{4'hB, 25'h0F4240}, '{4'hA, 25'h07A120}, '{4'h9, 25'h03D090}, '{4'h8, 25'h01E848},
    '{4'h7, 25'h07A120}, '{4'h6, 25'h03D090}, '{4'h5, 25'h01E848}, '{4'h4, 25'h00F424}};
  localparam logic [9:0] MIXT [4] = '{{8'hD0, 2'h3}, {8'hC9, 2'h1}, {8'hD9, 2'h2}, {8'hD1, 2'h0}};
  localparam logic [7:0] A_CTRL = 8'(occ_pkg::OFS_OSC_CTRL);
  localparam logic [7:0] A_STAT = 8'(occ_pkg::OFS_OSC_STAT);
  localparam logic [7:0] A_TUNE = 8'(occ_pkg::OFS_OSC_TUNE);
  localparam logic [7:0] A_REF  = 8'(occ_pkg::OFS_REFGEN_CTRL);
  logic aclk, aresetn, clr, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pll_active_q, refgen_output_pin_q;
  logic refgen_output_pin_oe_q, refgen_slew_limit_q, timer1_osc_enable, timer1_osc_running, pll_locked;
  logic osc_startup_timer_expired, hf_internal_osc_ready, hf_internal_osc_locked, hf_internal_osc_stable;
  logic mf_internal_osc_ready, lf_internal_osc_ready, config_pll_force, fosc_quarter_output_enable;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  osc_mode_config;
  logic [24:0] int_freq_hz_q;
  logic [5:0]  freq_trim_q;
  logic [15:0] high_cnt_q, rise_cnt_q;
  occ_pkg::occ_int_src_e int_src_q;
  occ_pkg::occ_sys_src_e sysclk_src_q;
  occ_pkg::occ_mix_e     refgen_clk_mix_q;
  int err_count, total_checks, cyc;

  occ_top #(.ADDR_W(32), .CNT_W(7)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .timer1_osc_enable, .timer1_osc_running, .pll_locked, .osc_startup_timer_expired, .hf_internal_osc_ready,
    .hf_internal_osc_locked, .hf_internal_osc_stable, .mf_internal_osc_ready, .lf_internal_osc_ready,
    .osc_mode_config, .config_pll_force, .fosc_quarter_output_enable, .int_src_q, .int_freq_hz_q, .pll_active_q,
    .sysclk_src_q, .freq_trim_q, .refgen_output_pin_q, .refgen_output_pin_oe_q, .refgen_clk_mix_q,
    .refgen_slew_limit_q);
  occ_ext_dev i_ext (.aclk, .pin(refgen_output_pin_q), .oe(refgen_output_pin_oe_q), .clr, .high_cnt_q,
    .rise_cnt_q);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic tally_and_finish();
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    {s_axi_awaddr, s_axi_wdata} <= {24'h0, a, 24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    repeat (4) @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    s_axi_araddr <= {24'h0, a};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", {24'h0, ed}, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    @(posedge aclk);
  endtask : rd

  task automatic pin_win(input logic [15:0] eh, input logic [15:0] er);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (41) @(posedge aclk);
    chk("highs", {16'h0, eh}, {16'h0, high_cnt_q});
    chk("rises", {16'h0, er}, {16'h0, rise_cnt_q});
  endtask : pin_win

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, clr, aresetn} = 7'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, err_count, total_checks, cyc} = '0;
    {s_axi_wstrb, osc_mode_config, config_pll_force, fosc_quarter_output_enable} = {4'h1, 3'h4, 2'h0};
    {timer1_osc_enable, timer1_osc_running, pll_locked, osc_startup_timer_expired} = 4'h0;
    {hf_internal_osc_ready, hf_internal_osc_locked, hf_internal_osc_stable} = 3'h0;
    {mf_internal_osc_ready, lf_internal_osc_ready} = 2'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("freq", 32'h7A120, {7'h0, int_freq_hz_q});
    rd(A_CTRL, 8'h38, occ_pkg::RESP_OKAY);
    rd(A_REF, 8'h10, occ_pkg::RESP_OKAY);
    rd(A_STAT, 8'h80, occ_pkg::RESP_OKAY);
    rd(8'h10, 8'h00, occ_pkg::RESP_SLVERR);
    wr(8'h10, 8'h55, occ_pkg::RESP_SLVERR);
    for (int i = 0; i < 12; i++) begin
      wr(A_CTRL, {1'b0, ROWS[i].code, 3'h0}, occ_pkg::RESP_OKAY);
      chk("freq", {7'h0, ROWS[i].hz}, {7'h0, int_freq_hz_q});
      chk("src", {29'h0, ROWS[i].code[3] ? 3'h4 : 3'h2}, {29'h0, int_src_q});
    end
    for (int s = 0; s < 4; s++) begin
      wr(A_CTRL, {6'h0E, 2'(s)}, occ_pkg::RESP_OKAY);
      chk("sys", 32'(1 << (s > 1 ? 2 : s)), {29'h0, sysclk_src_q});
    end
    wr(A_CTRL, 8'hF4, occ_pkg::RESP_OKAY);
    rd(A_CTRL, 8'hF0, occ_pkg::RESP_OKAY);
    chk("freq", 32'h1E84800, {7'h0, int_freq_hz_q});
    chk("pll", 32'h1, {31'h0, pll_active_q});
    wr(A_TUNE, 8'hE0, occ_pkg::RESP_OKAY);
    rd(A_TUNE, 8'h20, occ_pkg::RESP_OKAY);
    chk("trim", 32'h20, {26'h0, freq_trim_q});
    // Status bits with Timer1 not yet running.
    {timer1_osc_enable, pll_locked, osc_startup_timer_expired, hf_internal_osc_ready} <= 4'hF;
    {hf_internal_osc_locked, hf_internal_osc_stable, mf_internal_osc_ready, lf_internal_osc_ready} <= 4'hF;
    wr(A_CTRL, 8'h38, occ_pkg::RESP_OKAY);
    rd(A_STAT, 8'h7F, occ_pkg::RESP_OKAY);
    timer1_osc_running <= 1'b1;
    wr(A_CTRL, 8'h3A, occ_pkg::RESP_OKAY);
    rd(A_STAT, 8'hDF, occ_pkg::RESP_OKAY);
    // Program the generator before driving the pin.
    for (int d = 0; d < 4; d++) begin
      wr(A_REF, {3'h0, 2'(d), 3'h3}, occ_pkg::RESP_OKAY);
      wr(A_REF, {3'h6, 2'(d), 3'h3}, occ_pkg::RESP_OKAY);
      chk("oe", 32'h1, {31'h0, refgen_output_pin_oe_q});
      pin_win(16'(10 * d), d == 0 ? 16'h0 : 16'h5);
    end
    wr(A_REF, 8'hD2, occ_pkg::RESP_OKAY);
    pin_win(16'h14, 16'hA);
    for (int m = 0; m < 4; m++) begin
      wr(A_REF, MIXT[m][9:2], occ_pkg::RESP_OKAY);
      chk("mix", {30'h0, MIXT[m][1:0]}, {30'h0, refgen_clk_mix_q});
    end
    wr(A_REF, 8'hF2, occ_pkg::RESP_OKAY);
    chk("slew", 32'h1, {31'h0, refgen_slew_limit_q});
    wr(A_REF, 8'h92, occ_pkg::RESP_OKAY);
    chk("slew", 32'h0, {31'h0, refgen_slew_limit_q});
    pin_win(16'h0, 16'h0);
    wr(A_REF, 8'h52, occ_pkg::RESP_OKAY);
    chk("oe", 32'h0, {31'h0, refgen_output_pin_oe_q});
    wr(A_REF, 8'hD3, occ_pkg::RESP_OKAY);
    for (int m = 0; m < 3; m++) begin
      osc_mode_config <= 3'(m);
      repeat (5) @(posedge aclk);
      chk("oe", 32'h0, {31'h0, refgen_output_pin_oe_q});
    end
    {osc_mode_config, fosc_quarter_output_enable} <= 4'h9;
    repeat (5) @(posedge aclk);
    pin_win(16'h14, 16'hA);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    fosc_quarter_output_enable <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("oe", 32'h0, {31'h0, refgen_output_pin_oe_q});
    rd(A_REF, 8'h10, occ_pkg::RESP_OKAY);
    tally_and_finish();
  end
endmodule : osc_control_and_ref_clock_out_bench
